// ---- rtl/fcd_map.svh ----
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH

// ------------------------------------------------------------
// instruction opcodes and control parts
// ------------------------------------------------------------
`define FCD_OP_TO_DOUBLE 4'h4
`define FCD_OP_TO_INT 4'h5
`define FCD_CTL_SHORT 16'h1F00
`define FCD_CTL_HOST_REG 16'h5F00
`define FCD_CTL_MEM_SINGLE 16'h9F00
`define FCD_CTL_MEM_DOUBLE 16'h9F80

// ------------------------------------------------------------
// operand transfer counts
// ------------------------------------------------------------
`define FCD_WORDS_NONE 2'h0
`define FCD_WORDS_ONE 2'h1
`define FCD_WORDS_TWO 2'h2

// ------------------------------------------------------------
// register file layout
// ------------------------------------------------------------
`define FCD_FILE_A 1'b0
`define FCD_WORD_PAD 32'h0000_0000

// ------------------------------------------------------------
// number format constants
// ------------------------------------------------------------
`define FCD_SP_BIAS 8'h7F
`define FCD_SP_SAT_EXP 8'h9E
`define FCD_SP_EXP_MAX 8'hFF
`define FCD_DP_BIAS 11'h3FF
`define FCD_DP_SAT_EXP 11'h41E
`define FCD_DP_EXP_MAX 11'h7FF
`define FCD_EXP_REBIAS 11'h380
`define FCD_INT_MAX 32'h7FFF_FFFF
`define FCD_INT_MIN 32'h8000_0000

`endif

// ---- rtl/fcd_pkg.sv ----
package fcd_pkg;

    // ------------------------------------------------------------
    // instruction word, most significant field first
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sel;
        logic [3:0] src;
        logic [3:0] op;
        logic [4:0] dst;
        logic [15:0] ctrl;
    } fcd_instr_t;

    // ------------------------------------------------------------
    // conversion kinds and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NONE = 2'h0,
        KIND_S2D = 2'h1,
        KIND_S2I = 2'h2,
        KIND_D2I = 2'h3
    } fcd_kind_t;

    typedef struct packed {
        fcd_kind_t kind;
        logic [1:0] nWords;
    } fcd_dec_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_EXEC = 2'h3
    } fcd_state_t;

    // ------------------------------------------------------------
    // register file write port
    // ------------------------------------------------------------
    typedef struct packed {
        logic weLo;
        logic weHi;
        logic [4:0] addr;
        logic [63:0] data;
    } fcd_wr_t;

endpackage

// ---- rtl/fcd_regfile.sv ----
module fcd_regfile (
    // clock
    input wire logic mclk,
    // write port, halves enabled separately
    input wire fcd_pkg::fcd_wr_t wr,
    // read ports
    input wire logic [4:0] rAddrA,
    output logic [63:0] rDataA,
    input wire logic [4:0] rAddrB,
    output logic [63:0] rDataB
);

    // 32 entries: file A in the lower half, file B in the upper
    logic [63:0] mem [0:31];

    // half writes let a double arrive as two words
    always_ff @(posedge mclk) begin
        if (wr.weLo) begin
            mem[wr.addr][31:0] <= wr.data[31:0];
        end
        if (wr.weHi) begin
            mem[wr.addr][63:32] <= wr.data[63:32];
        end
    end

    // asynchronous reads
    assign rDataA = mem[rAddrA];
    assign rDataB = mem[rAddrB];

endmodule

// ---- rtl/fcd_conv_unit.sv ----
`include "fcd_map.svh"

module fcd_conv_unit (
    // operation and operand
    input wire fcd_pkg::fcd_kind_t kind,
    input wire logic [63:0] srcVal,
    // converted value
    output logic [63:0] result
);

    // widening is exact; denormal singles flush to signed zero
    function automatic logic [63:0] singleToDouble(input logic [31:0] s);
        logic [7:0] e;
        e = s[30:23];
        if (e == 8'h00) return {s[31], 63'h0};
        if (e == `FCD_SP_EXP_MAX) return {s[31], `FCD_DP_EXP_MAX, s[22:0], 29'h0};
        return {s[31], {3'h0, e} + `FCD_EXP_REBIAS, s[22:0], 29'h0};
    endfunction

    // truncates toward zero, saturates out of range, nan gives max
    function automatic logic [31:0] singleToInt(input logic [31:0] s);
        logic [7:0] e;
        logic [55:0] wide;
        logic [31:0] mag;
        e = s[30:23];
        wide = {32'h0, 1'b1, s[22:0]};
        if (e == `FCD_SP_EXP_MAX && s[22:0] != 23'h0) return `FCD_INT_MAX;
        if (e < `FCD_SP_BIAS) return 32'h0;
        if (e >= `FCD_SP_SAT_EXP) return s[31] ? `FCD_INT_MIN : `FCD_INT_MAX;
        wide = wide << (e - `FCD_SP_BIAS);
        mag = wide[54:23];
        return s[31] ? -mag : mag;
    endfunction

    function automatic logic [31:0] doubleToInt(input logic [63:0] d);
        logic [10:0] e;
        logic [83:0] wide;
        logic [31:0] mag;
        e = d[62:52];
        wide = {31'h0, 1'b1, d[51:0]};
        if (e == `FCD_DP_EXP_MAX && d[51:0] != 52'h0) return `FCD_INT_MAX;
        if (e < `FCD_DP_BIAS) return 32'h0;
        if (e >= `FCD_DP_SAT_EXP) return d[63] ? `FCD_INT_MIN : `FCD_INT_MAX;
        wide = wide << (e - `FCD_DP_BIAS);
        mag = wide[83:52];
        return d[63] ? -mag : mag;
    endfunction

    // integers sit in the low word with the high word cleared
    always_comb begin
        case (kind)
            fcd_pkg::KIND_S2D: result = singleToDouble(srcVal[31:0]);
            fcd_pkg::KIND_S2I: result = {`FCD_WORD_PAD, singleToInt(srcVal[31:0])};
            fcd_pkg::KIND_D2I: result = {`FCD_WORD_PAD, doubleToInt(srcVal)};
            default: result = 64'h0;
        endcase
    end

endmodule

// ---- rtl/fcd_decode_top.sv ----
`include "fcd_map.svh"

module fcd_decode_top #(
    // identity of this coprocessor; value is arbitrary
    parameter logic [2:0] COPROC_SEL = 3'h2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // instruction port
    input wire logic instrValid,
    input wire fcd_pkg::fcd_instr_t instr,
    output logic instrReady,
    // operand word port
    input wire logic wordValid,
    input wire logic [31:0] word,
    output logic wordReady,
    // status
    output logic busy,
    output logic done,
    output logic [4:0] doneDest,
    output logic badCmd,
    // register file view
    input wire logic [4:0] dbgAddr,
    output logic [63:0] dbgData
);

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------

    // shared by the sequencer and the checks below
    function automatic fcd_pkg::fcd_dec_t decodeWord(input fcd_pkg::fcd_instr_t w);
        fcd_pkg::fcd_dec_t d;
        d.kind = fcd_pkg::KIND_NONE;
        d.nWords = `FCD_WORDS_NONE;
        if (w.op == `FCD_OP_TO_DOUBLE) begin
            case (w.ctrl)
                `FCD_CTL_SHORT: d.kind = fcd_pkg::KIND_S2D;
                `FCD_CTL_HOST_REG, `FCD_CTL_MEM_SINGLE: begin
                    d.kind = fcd_pkg::KIND_S2D;
                    d.nWords = `FCD_WORDS_ONE;
                end
                default: d.kind = fcd_pkg::KIND_NONE;
            endcase
        end else if (w.op == `FCD_OP_TO_INT) begin
            case (w.ctrl)
                `FCD_CTL_SHORT: d.kind = fcd_pkg::KIND_S2I;
                `FCD_CTL_MEM_DOUBLE: begin
                    d.kind = fcd_pkg::KIND_D2I;
                    d.nWords = `FCD_WORDS_TWO;
                end
                default: d.kind = fcd_pkg::KIND_NONE;
            endcase
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    fcd_pkg::fcd_state_t state_r, state_nxt;
    fcd_pkg::fcd_instr_t cmd_r, cmd_nxt;
    fcd_pkg::fcd_kind_t kind_r, kind_nxt;
    logic [1:0] nWords_r, nWords_nxt;
    logic [1:0] wordsLeft_r, wordsLeft_nxt;
    logic done_r, done_nxt;
    logic [4:0] doneDest_r, doneDest_nxt;
    logic badCmd_r, badCmd_nxt;
    logic [63:0] dbgData_r;
    fcd_pkg::fcd_dec_t dec;
    fcd_pkg::fcd_wr_t wr;
    logic [63:0] srcVal;
    logic [63:0] convVal;
    logic [63:0] dbgRead;
    logic [4:0] srcAddr;
    logic takeInstr;
    logic selected;

    assign dec = decodeWord(instr);
    assign instrReady = (state_r == fcd_pkg::ST_IDLE);
    assign wordReady = (state_r == fcd_pkg::ST_LOAD);
    assign takeInstr = instrValid && instrReady;
    assign selected = (instr.sel == COPROC_SEL);
    // source index always lands in file A
    assign srcAddr = {`FCD_FILE_A, cmd_r.src};

    // next state, register writes and status
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        kind_nxt = kind_r;
        nWords_nxt = nWords_r;
        wordsLeft_nxt = wordsLeft_r;
        done_nxt = 1'b0;
        doneDest_nxt = doneDest_r;
        badCmd_nxt = 1'b0;
        wr = '0;
        case (state_r)
            fcd_pkg::ST_IDLE: begin
                if (takeInstr && selected) begin
                    if (dec.kind == fcd_pkg::KIND_NONE) begin
                        badCmd_nxt = 1'b1;
                    end else begin
                        cmd_nxt = instr;
                        kind_nxt = dec.kind;
                        nWords_nxt = dec.nWords;
                        wordsLeft_nxt = dec.nWords;
                        if (dec.nWords == `FCD_WORDS_NONE) begin
                            state_nxt = fcd_pkg::ST_EXEC;
                        end else begin
                            state_nxt = fcd_pkg::ST_LOAD;
                        end
                    end
                end
            end
            fcd_pkg::ST_LOAD: begin
                // operand words go to the source register
                if (wordValid) begin
                    wr.addr = srcAddr;
                    wr.data = {word, word};
                    // first word low half, second high half
                    if (nWords_r == `FCD_WORDS_TWO && wordsLeft_r == `FCD_WORDS_ONE) begin
                        wr.weHi = 1'b1;
                    end else begin
                        wr.weLo = 1'b1;
                        // a single clears the stale high half
                        wr.weHi = (nWords_r == `FCD_WORDS_ONE);
                        wr.data[63:32] = (nWords_r == `FCD_WORDS_ONE) ? `FCD_WORD_PAD : word;
                    end
                    wordsLeft_nxt = wordsLeft_r - 2'h1;
                    if (wordsLeft_r == `FCD_WORDS_ONE) begin
                        state_nxt = fcd_pkg::ST_EXEC;
                    end
                end
            end
            fcd_pkg::ST_EXEC: begin
                wr.weLo = 1'b1;
                wr.weHi = 1'b1;
                wr.addr = cmd_r.dst;
                wr.data = convVal;
                done_nxt = 1'b1;
                doneDest_nxt = cmd_r.dst;
                state_nxt = fcd_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = fcd_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= fcd_pkg::ST_IDLE;
            cmd_r <= '0;
            kind_r <= fcd_pkg::KIND_NONE;
            nWords_r <= `FCD_WORDS_NONE;
            wordsLeft_r <= `FCD_WORDS_NONE;
            done_r <= 1'b0;
            doneDest_r <= 5'h00;
            badCmd_r <= 1'b0;
            dbgData_r <= 64'h0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            kind_r <= kind_nxt;
            nWords_r <= nWords_nxt;
            wordsLeft_r <= wordsLeft_nxt;
            done_r <= done_nxt;
            doneDest_r <= doneDest_nxt;
            badCmd_r <= badCmd_nxt;
            dbgData_r <= dbgRead;
        end
    end

    assign busy = (state_r != fcd_pkg::ST_IDLE);
    assign done = done_r;
    assign doneDest = doneDest_r;
    assign badCmd = badCmd_r;
    assign dbgData = dbgData_r;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    fcd_regfile u_regs (
        .mclk(mclk),
        .wr(wr),
        .rAddrA(srcAddr),
        .rDataA(srcVal),
        .rAddrB(dbgAddr),
        .rDataB(dbgRead)
    );

    // conversion is one combinational pass, written in exec
    fcd_conv_unit u_conv (
        .kind(kind_r),
        .srcVal(srcVal),
        .result(convVal)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_field_decode: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && dec.kind != fcd_pkg::KIND_NONE
        |=> cmd_r.dst == $past(instr[20:16]) && cmd_r.op == $past(instr[24:21]))
        else $error("instruction fields not latched");

    a_short_double: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && instr.op == `FCD_OP_TO_DOUBLE && instr.ctrl == `FCD_CTL_SHORT
        |=> state_r == fcd_pkg::ST_EXEC ##1 done && state_r == fcd_pkg::ST_IDLE)
        else $error("short widen did not finish in two cycles");

    a_short_int: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && instr.op == `FCD_OP_TO_INT && instr.ctrl == `FCD_CTL_SHORT
        |=> kind_r == fcd_pkg::KIND_S2I && !wordReady ##1 done)
        else $error("short integer conversion mishandled");

    a_one_word: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && instr.op == `FCD_OP_TO_DOUBLE
        && (instr.ctrl == `FCD_CTL_HOST_REG || instr.ctrl == `FCD_CTL_MEM_SINGLE)
        |=> wordReady && wordsLeft_r == `FCD_WORDS_ONE)
        else $error("single transfer form did not wait for one word");

    a_two_words: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && instr.op == `FCD_OP_TO_INT && instr.ctrl == `FCD_CTL_MEM_DOUBLE
        |=> wordReady && wordsLeft_r == `FCD_WORDS_TWO)
        else $error("double transfer form did not wait for two words");

    a_store_source: assert property (
        @(posedge mclk) disable iff (!nrst)
        wordReady && wordValid |-> wr.addr == srcAddr && (wr.data[31:0] == word || wr.weHi && !wr.weLo))
        else $error("operand word not steered to source register");

    a_dest_only: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_r == fcd_pkg::ST_EXEC |-> wr.addr == cmd_r.dst && wr.weLo && wr.weHi
        ##1 !wr.weLo && !wr.weHi)
        else $error("exec wrote other than the destination");

    a_widen_exp: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_r == fcd_pkg::ST_EXEC && kind_r == fcd_pkg::KIND_S2D
        && srcVal[30:23] != 8'h00 && srcVal[30:23] != `FCD_SP_EXP_MAX
        |-> convVal[62:52] == {3'h0, srcVal[30:23]} + `FCD_EXP_REBIAS && convVal[63] == srcVal[31])
        else $error("widened exponent wrong");

    a_int_unit: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_r == fcd_pkg::ST_EXEC && kind_r == fcd_pkg::KIND_S2I && srcVal[30:23] == `FCD_SP_BIAS
        |-> convVal == (srcVal[31] ? 64'h0000_0000_FFFF_FFFF : 64'h0000_0000_0000_0001))
        else $error("single in one to two not converted to one");

    a_dbl_int_unit: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_r == fcd_pkg::ST_EXEC && kind_r == fcd_pkg::KIND_D2I && srcVal[62:52] == `FCD_DP_BIAS
        && !srcVal[63] |-> convVal == 64'h0000_0000_0000_0001)
        else $error("double in one to two not converted to one");

    a_foreign_skip: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && !selected |=> state_r == fcd_pkg::ST_IDLE && !badCmd && !done)
        else $error("foreign instruction acted upon");

    // unknown selected words leave the sequencer idle and raise only the refusal
    a_bad_refuse: assert property (
        @(posedge mclk) disable iff (!nrst)
        takeInstr && selected && dec.kind == fcd_pkg::KIND_NONE
        |=> badCmd && state_r == fcd_pkg::ST_IDLE && !done)
        else $error("unknown instruction not refused");

    a_second_word: assert property (
        @(posedge mclk) disable iff (!nrst)
        wordReady && wordValid && nWords_r == `FCD_WORDS_TWO && wordsLeft_r == `FCD_WORDS_ONE
        |-> wr.weHi && !wr.weLo && wr.data[63:32] == word)
        else $error("second word not placed in high half");

endmodule

// ---- tb/fcd_host_model.sv ----
module fcd_host_model (
    // clock
    input wire logic mclk,
    // operand word port
    input wire logic wordReady,
    output logic wordValid,
    output logic [31:0] word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [0:63];
    logic [31:0] ptr;
    int misses;
    bit slow;

    // idle until the bench asks for operand words
    initial begin
        wordValid = 1'b0;
        word = 32'h0;
        ptr = 32'h0;
        misses = 0;
    end

    // ----------------------------------------
    // one word, held until the device takes it
    // ----------------------------------------
    task automatic offer(input logic [31:0] w);
        int k;
        wordValid = 1'b1;
        word = w;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (wordReady === 1'b1) break;
        end
        if (k == 50) misses++;
        #1;
        // slow host: gap between words, stale word scrambled
        if (slow) begin
            wordValid = 1'b0;
            word = ~w;
            repeat (2) @(posedge mclk);
            #1;
        end
    endtask

    // mode 0 host register, 1 post-increment, 2 pre-decrement
    task automatic fetch(input int mode, input int n, input logic [31:0] regWord);
        for (int i = 0; i < n; i++) begin
            if (mode == 0) offer(regWord);
            else if (mode == 1) begin
                offer(mem[ptr[10:5]]);
                ptr = ptr + 32'h20;
            end
            else begin
                ptr = ptr - 32'h20;
                offer(mem[ptr[10:5]]);
            end
        end
        // released line no longer shows the last word; slow host already scrambled it
        wordValid = 1'b0;
        if (!slow) word = ~word;
    endtask
endmodule

// ---- tb/fp_format_convert_decode_test.sv ----
module fp_format_convert_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [4:0] dst;
        logic [63:0] val;
        logic chkSrc;
        logic [4:0] src;
        logic [63:0] srcVal;
    } fcd_exp_t;
    localparam logic [2:0] SEL = 3'h5;
    logic mclk = 1'b0;
    logic nrst, instrValid, wordValid, wordReady, instrReady, busy, done, badCmd;
    fcd_pkg::fcd_instr_t instr;
    logic [31:0] word, r, seed = 32'h58EA_A36C;
    logic [4:0] doneDest;
    logic [4:0] dbgAddr = 5'h0;
    logic [63:0] dbgData, d, v;
    int errTotal, comparisons, badSeen;
    bit monBusy;
    fcd_exp_t expQ [$];
    fcd_exp_t got;
    logic [31:0] sv [11] = '{32'h0, 32'h8000_0001, 32'h7F80_0000, 32'hFF80_0000, 32'h7FC0_0001, 32'hBFC0_0000,
        32'h4F00_0000, 32'hCF00_0000, 32'h3F7F_FFFF, 32'h4B7F_FFFF, 32'h4E80_0000};
    logic [63:0] dv [7] = '{64'h41E0_0000_0000_0000, 64'hC1E0_0000_0000_0000, 64'h7FF8_0000_0000_0001,
        64'h3FEF_FFFF_FFFF_FFFF, 64'hC000_0000_0000_0000, 64'h41DF_FFFF_FFC0_0000, 64'h3FF8_0000_0000_0000};

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    always #5 mclk = ~mclk;
    fcd_decode_top #(.COPROC_SEL(SEL)) uut (.mclk(mclk), .nrst(nrst), .instrValid(instrValid), .instr(instr),
        .instrReady(instrReady), .wordValid(wordValid), .word(word), .wordReady(wordReady), .busy(busy),
        .done(done), .doneDest(doneDest), .badCmd(badCmd), .dbgAddr(dbgAddr), .dbgData(dbgData));
    fcd_host_model host (.mclk(mclk), .wordReady(wordReady), .wordValid(wordValid), .word(word));

    // ----------------------------------------
    // reference arithmetic
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // denormals flush to signed zero, inf and nan keep payload
    function automatic logic [63:0] s2d(input logic [31:0] f);
        if (f[30:23] == 8'h00) return {f[31], 63'h0};
        if (f[30:23] == 8'hFF) return {f[31], 11'h7FF, f[22:0], 29'h0};
        return {f[31], {3'h0, f[30:23]} + 11'h380, f[22:0], 29'h0};
    endfunction

    // truncate toward zero, saturate out of range, nan to max
    function automatic logic [63:0] toInt(input logic s, input logic nan, input int e, input logic [63:0] m,
                                          input int fb);
        logic [63:0] q;
        if (nan) return 64'h7FFF_FFFF;
        if (e < 0) return 64'h0;
        if (e >= 31) return s ? 64'h8000_0000 : 64'h7FFF_FFFF;
        q = (e >= fb) ? m << (e - fb) : m >> (fb - e);
        return {32'h0, s ? -q[31:0] : q[31:0]};
    endfunction

    function automatic logic [63:0] s2i(input logic [31:0] f);
        return toInt(f[31], f[30:23] == 8'hFF && f[22:0] != 0, int'(f[30:23]) - 127, {40'h1, f[22:0]}, 23);
    endfunction

    function automatic logic [63:0] d2i(input logic [63:0] f);
        return toInt(f[63], f[62:52] == 11'h7FF && f[51:0] != 0, int'(f[62:52]) - 1023, {12'h1, f[51:0]}, 52);
    endfunction

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [63:0] g, input logic [63:0] exp, input string what);
        comparisons++;
        if (g !== exp) begin
            errTotal++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, exp);
        end
    endtask

    task automatic reportAndStop();
        errTotal += host.misses;
        $display("counts: %0d compared, %0d errors", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // result watcher: oldest note against each done pulse
    always begin
        @(posedge mclk);
        if (done === 1'b1) begin
            monBusy = 1;
            if (expQ.size() == 0) chk(64'h1, 64'h0, "done without request");
            else begin
                got = expQ.pop_front();
                chk(64'(doneDest), 64'(got.dst), "dest index");
                #1 dbgAddr = got.dst;
                @(posedge mclk);
                #1;
                chk(dbgData, got.val, "result");
                if (got.chkSrc) begin
                    dbgAddr = got.src;
                    @(posedge mclk);
                    #1;
                    chk(dbgData, got.srcVal, "source contents");
                end
            end
            monBusy = 0;
        end
    end

    // refusal pulses are counted, latency is left to the design checks
    always @(posedge mclk) if (badCmd === 1'b1) badSeen++;

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic issue(input logic [2:0] sel, input logic [3:0] src, input logic [3:0] op, input logic [4:0] dst,
                         input logic [15:0] ctl, input bit hold);
        int k;
        instrValid = 1'b1;
        instr = {sel, src, op, dst, ctl};
        for (k = 0; k < 100; k++) begin
            @(posedge mclk);
            if (instrReady === 1'b1) break;
        end
        #1;
        if (!hold) begin
            instrValid = 1'b0;
            instr = ~instr;
        end
        if (k == 100) begin
            errTotal++;
            reportAndStop();
        end
    endtask

    task automatic settle();
        int k;
        for (k = 0; k < 200 && (expQ.size() != 0 || monBusy); k++) @(posedge mclk);
        if (k == 200) begin
            errTotal++;
            reportAndStop();
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // forms: 0 short widen, 1 short to int, 2 register widen, 3/4 memory widen, 5 memory double
    task automatic conv(input int form, input logic [3:0] src, input logic [4:0] dst, input logic [63:0] x,
                        input bit hold);
        fcd_exp_t e;
        e.dst = dst;
        e.val = form == 1 ? s2i(x[31:0]) : form == 5 ? d2i(x) : s2d(x[31:0]);
        e.chkSrc = form >= 2;
        e.src = {1'b0, src};
        e.srcVal = form == 5 ? x : {32'h0, x[31:0]};
        host.ptr = 32'h400;
        host.mem[32] = x[31:0];
        host.mem[31] = x[31:0];
        host.mem[30] = x[63:32];
        expQ.push_back(e);
        issue(SEL, src, form == 1 || form == 5 ? 4'h5 : 4'h4, dst,
              form < 2 ? 16'h1F00 : form == 2 ? 16'h5F00 : form == 5 ? 16'h9F80 : 16'h9F00, hold);
        if (form >= 2) host.fetch(form < 4 ? form - 2 : 2, form == 5 ? 2 : 1, x[31:0]);
        if (!hold) settle();
    endtask

    task automatic badTry(input logic [2:0] sel, input logic [3:0] op, input logic [15:0] ctl, input int want);
        int b0;
        b0 = badSeen;
        issue(sel, 4'h1, op, 5'h11, ctl, 0);
        repeat (4) @(posedge mclk);
        #1;
        chk(64'(badSeen - b0), 64'(want), "refusal pulses");
        chk(64'(busy), 64'h0, "idle after word");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        instrValid = 1'b0;
        instr = '0;
        repeat (8) @(posedge mclk);
        #1;
        chk({instrReady, wordReady, busy, done, badCmd, doneDest}, 64'h200, "reset outputs");
        chk(dbgData, 64'h0, "reset view");
        repeat (8) @(posedge mclk);
        #1 nrst = 1'b1;
        foreach (sv[i]) begin
            conv(2 + i % 3, 4'hF, 5'h1F, {32'h0, sv[i]}, 0);
            conv(1, 4'hF, 5'h1E, {32'h0, sv[i]}, 0);
        end
        foreach (dv[i]) conv(5, 4'h2, 5'h1D, dv[i], 0);
        $display("test edge values done, errors %0d", errTotal);
        for (int i = 0; i < 12; i++) begin
            r = xs();
            host.slow = r[1];
            v = {32'h0, r[31], 8'h70 + 8'(r[29:23]), r[22:0]};
            conv(2 + int'(r[3:2]) % 3, 4'(i), 5'h10 + 5'(i), v, 0);
            conv(0, 4'(i), 5'h1C, v, 0);
            conv(1, 4'(i), 5'h1B, v, 0);
            d = {xs(), xs()};
            d[62:52] = 11'h3E0 + 11'(r[10:4]);
            conv(5, 4'(i), 5'h1A, d, 0);
        end
        host.slow = 0;
        $display("test random operands done, errors %0d", errTotal);
        conv(2, 4'h3, 5'h14, 64'h4049_0FDB, 0);
        conv(0, 4'h3, 5'h15, 64'h4049_0FDB, 1);
        conv(1, 4'h3, 5'h16, 64'h4049_0FDB, 0);
        $display("test back to back done, errors %0d", errTotal);
        badTry(SEL, 4'h7, 16'h1F00, 1);
        badTry(SEL, 4'h4, 16'h1234, 1);
        badTry(SEL, 4'h5, 16'h5F01, 1);
        badTry(SEL + 3'h1, 4'h4, 16'h1F00, 0);
        badTry(~SEL, 4'h5, 16'h9F80, 0);
        $display("test refusals done, errors %0d", errTotal);
        reportAndStop();
    end
endmodule
